// file: core/dpcfg_decoder.sv
// Module layout byte walker and error reply classifier with AXI4-Lite
// Summary of operation
// - Nibble 0000B: no data, skip vendor bytes
// - Codes 1-3: bytes, no consistency, in/out/both
// - Codes 5-7: words, no consistency, in/out/both
// - Codes 9-B: bytes, consistent, in/out/both
// - Codes D-F: words, consistent, in/out/both
// - Length is low nibble plus one
// - Both-direction codes share one length
// - Code 4: one input descriptor follows
// - Code 8: one output descriptor follows
// - Code C: output then input descriptor
// - Descriptor bits 6-7 give unit, consistency
// - Descriptor length is low six bits plus one
// - Byte zero names failed service
// - Byte one names error decode
// - Byte two class/code, application class
// - Class 0x0B access codes 0 to 9
// - Class 0x0C resource codes 0 to 3
`timescale 1ns/1ps
module dpcfg_decoder
  import dpcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // Interrupt
  output logic             IRQ_O
);

  // Walker states
  typedef enum logic [3:0] {
    ST_ID   = 4'h1,
    ST_DOUT = 4'h2,
    ST_DIN  = 4'h4,
    ST_SKIP = 4'h8
  } dpcfg_state_t;

  // Decode a descriptor byte into a direction record
  function automatic dpcfg_dir_t desc_dec(input logic [7:0] b);
    dpcfg_dir_t d;
    d.present    = 1'b1;
    d.word       = b[6];
    d.consistent = b[7];
    d.units      = {1'b0, b[5:0]} + 7'h01;
    return d;
  endfunction

  // Bytes taken by a direction record
  function automatic logic [7:0] dir_bytes(input dpcfg_dir_t d);
    logic [7:0] n;
    n = {1'b0, d.units};
    if (!d.present)
      n = 8'h00;
    else if (d.word)
      n = {d.units, 1'b0};
    return n;
  endfunction

  // Bus handshake state
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_go;

  // Decoder state
  dpcfg_state_t state_r;
  logic [3:0]   skip_r;
  dpcfg_dir_t   din_r;
  dpcfg_dir_t   dout_r;
  logic [7:0]   hdr_r;
  logic [15:0]  in_total_r;
  logic [15:0]  out_total_r;
  logic [7:0]   err_b_r [4];
  logic [2:0]   err_cnt_r;
  dpcfg_err_t   err_cls;
  logic [DPCFG_IRQ_W-1:0] irq_st_r;
  logic [DPCFG_IRQ_W-1:0] irq_msk_r;

  // Write-side strobes
  logic       cfg_wr;
  logic       err_wr;
  logic       ctl_wr;
  logic       irq_wr;
  logic       msk_wr;
  logic       module_done;
  logic       err_done;
  dpcfg_dir_t plain_d;
  logic [7:0] byte_in;

  // Address and data may arrive in either order; each is held until both
  assign S_AXI_AWREADY_O = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY_O  = !w_held_r && !bvalid_r;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_ARREADY_O = !rvalid_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RDATA_O   = rdata_r;
  assign S_AXI_RRESP_O   = rresp_r;
  assign wr_go           = aw_held_r && w_held_r && !bvalid_r;

  // Capture write address and data
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= DPCFG_ZERO32;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR_I;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA_I;
        wstrb_r  <= S_AXI_WSTRB_I;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // Write decode; byte lane 0 carries every writable field
  always_comb
  begin
    cfg_wr = 1'b0;
    err_wr = 1'b0;
    ctl_wr = 1'b0;
    irq_wr = 1'b0;
    msk_wr = 1'b0;
    if (wr_go && wstrb_r[0])
    begin
      case (awaddr_r)
        DPCFG_CFGIN_OFS:  cfg_wr = 1'b1;
        DPCFG_ERRIN_OFS:  err_wr = 1'b1;
        DPCFG_CTRL_OFS:   ctl_wr = 1'b1;
        DPCFG_IRQST_OFS:  irq_wr = 1'b1;
        DPCFG_IRQMSK_OFS: msk_wr = 1'b1;
        default:          ;
      endcase
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= DPCFG_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      case (awaddr_r)
        DPCFG_CFGIN_OFS, DPCFG_ERRIN_OFS, DPCFG_CTRL_OFS,
        DPCFG_IRQST_OFS, DPCFG_IRQMSK_OFS, DPCFG_TOTALS_OFS,
        DPCFG_MODULE_OFS, DPCFG_ERRRAW_OFS, DPCFG_ERRCLS_OFS:
          bresp_r <= DPCFG_RESP_OKAY;
        default:
          bresp_r <= DPCFG_RESP_SLVERR;
      endcase
    end
    else if (bvalid_r && S_AXI_BREADY_I)
      bvalid_r <= 1'b0;
  end

  assign byte_in = wdata_r[7:0];

  // Plain identifier: unit in bit 6, consistency in bit 7
  always_comb
  begin
    plain_d.present    = 1'b1;
    plain_d.word       = byte_in[6];
    plain_d.consistent = byte_in[7];
    plain_d.units      = {3'h0, byte_in[3:0]} + 7'h01;
  end

  // Layout walker, one byte per write to the input register
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_r     <= ST_ID;
      skip_r      <= 4'h0;
      din_r       <= '0;
      dout_r      <= '0;
      hdr_r       <= 8'h00;
      in_total_r  <= 16'h0000;
      out_total_r <= 16'h0000;
      module_done <= 1'b0;
    end
    else
    begin
      module_done <= 1'b0;
      if (ctl_wr && wdata_r[DPCFG_CTRL_RESTART_BIT])
      begin
        state_r     <= ST_ID;
        skip_r      <= 4'h0;
        din_r       <= '0;
        dout_r      <= '0;
        in_total_r  <= 16'h0000;
        out_total_r <= 16'h0000;
      end
      else if (cfg_wr)
      begin
        case (state_r)
          ST_ID:
          begin
            hdr_r  <= byte_in;
            skip_r <= byte_in[3:0];
            din_r  <= '0;
            dout_r <= '0;
            case (byte_in[7:4])
              DPCFG_ID_NODATA:
              begin
                module_done <= (byte_in[3:0] == 4'h0);
                state_r <= (byte_in[3:0] == 4'h0) ? ST_ID : ST_SKIP;
              end
              DPCFG_ID_SPEC_IN:  state_r <= ST_DIN;
              DPCFG_ID_SPEC_OUT: state_r <= ST_DOUT;
              DPCFG_ID_SPEC_IO:  state_r <= ST_DOUT;
              default:
              begin
                // Bit 4 inputs, bit 5 outputs, one length shared
                if (byte_in[4])
                begin
                  din_r      <= plain_d;
                  in_total_r <= in_total_r + {8'h00, dir_bytes(plain_d)};
                end
                if (byte_in[5])
                begin
                  dout_r      <= plain_d;
                  out_total_r <= out_total_r +
                                 {8'h00, dir_bytes(plain_d)};
                end
                module_done <= 1'b1;
                state_r     <= ST_ID;
              end
            endcase
          end
          ST_DOUT:
          begin
            dout_r      <= desc_dec(byte_in);
            out_total_r <= out_total_r +
                           {8'h00, dir_bytes(desc_dec(byte_in))};
            // Combined format takes the input descriptor second
            if (hdr_r[7:4] == DPCFG_ID_SPEC_IO)
              state_r <= ST_DIN;
            else if (skip_r != 4'h0)
              state_r <= ST_SKIP;
            else
            begin
              state_r     <= ST_ID;
              module_done <= 1'b1;
            end
          end
          ST_DIN:
          begin
            din_r      <= desc_dec(byte_in);
            in_total_r <= in_total_r +
                          {8'h00, dir_bytes(desc_dec(byte_in))};
            if (skip_r != 4'h0)
              state_r <= ST_SKIP;
            else
            begin
              state_r     <= ST_ID;
              module_done <= 1'b1;
            end
          end
          ST_SKIP:
          begin
            skip_r <= skip_r - 4'h1;
            if (skip_r == 4'h1)
            begin
              state_r     <= ST_ID;
              module_done <= 1'b1;
            end
          end
          default: state_r <= ST_ID;
        endcase
      end
    end
  end

  // Error reply capture; a fifth byte before a clear is an overflow
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      err_b_r[0] <= 8'h00;
      err_b_r[1] <= 8'h00;
      err_b_r[2] <= 8'h00;
      err_b_r[3] <= 8'h00;
      err_cnt_r  <= 3'h0;
      err_done   <= 1'b0;
    end
    else
    begin
      err_done <= 1'b0;
      if (ctl_wr && wdata_r[DPCFG_CTRL_ERRCLR_BIT])
        err_cnt_r <= 3'h0;
      else if (err_wr && err_cnt_r != DPCFG_ERR_BYTES)
      begin
        err_b_r[err_cnt_r[1:0]] <= byte_in;
        err_cnt_r <= err_cnt_r + 3'h1;
        err_done  <= (err_cnt_r == DPCFG_ERR_BYTES - 3'h1);
      end
    end
  end

  // Classify the captured reply
  always_comb
  begin
    case (err_b_r[0])
      DPCFG_SVC_TRANSPORT: err_cls.service = DPCFG_SVC_K_TRANS;
      DPCFG_SVC_INITIATE:  err_cls.service = DPCFG_SVC_K_INIT;
      DPCFG_SVC_READ:      err_cls.service = DPCFG_SVC_K_READ;
      DPCFG_SVC_WRITE:     err_cls.service = DPCFG_SVC_K_WRITE;
      default:             err_cls.service = DPCFG_SVC_K_SLAVE;
    endcase
    case (err_b_r[1])
      DPCFG_DEC_DPV1: err_cls.decode = DPCFG_DEC_K_DPV1;
      DPCFG_DEC_FMS:  err_cls.decode = DPCFG_DEC_K_FMS;
      DPCFG_DEC_HART: err_cls.decode = DPCFG_DEC_K_HART;
      default:        err_cls.decode = DPCFG_DEC_K_UNDEF;
    endcase
    case (err_b_r[2][7:4])
      DPCFG_CLS_APP:
      begin
        err_cls.cls        = DPCFG_CLS_K_APP;
        err_cls.code_known = (err_b_r[2][3:0] <= DPCFG_APP_FAIL) ||
                             (err_b_r[2][3:0] == DPCFG_APP_VERS) ||
                             (err_b_r[2][3:0] == DPCFG_APP_FEAT);
      end
      DPCFG_CLS_ACCESS:
      begin
        err_cls.cls        = DPCFG_CLS_K_ACC;
        err_cls.code_known = (err_b_r[2][3:0] <= DPCFG_ACC_LAST);
      end
      DPCFG_CLS_RESOURCE:
      begin
        err_cls.cls        = DPCFG_CLS_K_RES;
        err_cls.code_known = (err_b_r[2][3:0] <= DPCFG_RES_LAST);
      end
      default:
      begin
        err_cls.cls        = DPCFG_CLS_K_OTHER;
        err_cls.code_known = 1'b0;
      end
    endcase
  end

  // Overflow is a write into a full capture that was not cleared
  logic ovf_now;
  assign ovf_now = err_wr && (err_cnt_r == DPCFG_ERR_BYTES) &&
                   !(ctl_wr && wdata_r[DPCFG_CTRL_ERRCLR_BIT]);

  // Sticky status; a new event wins over a clearing write
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      irq_st_r  <= '0;
      irq_msk_r <= DPCFG_IRQMSK_RST;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~(irq_wr ? wdata_r[DPCFG_IRQ_W-1:0] : '0))
                  | {ovf_now, err_done, module_done};
      if (msk_wr)
        irq_msk_r <= wdata_r[DPCFG_IRQ_W-1:0];
    end
  end

  assign IRQ_O = |(irq_st_r & irq_msk_r);

  // Read path; unmapped offsets answer SLVERR with zero data
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= DPCFG_ZERO32;
      rresp_r  <= DPCFG_RESP_OKAY;
    end
    else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= DPCFG_RESP_OKAY;
      case (S_AXI_ARADDR_I)
        DPCFG_CTRL_OFS:   rdata_r <= {28'h0, state_r};
        DPCFG_CFGIN_OFS:  rdata_r <= {24'h0, hdr_r};
        DPCFG_ERRIN_OFS:  rdata_r <= {29'h0, err_cnt_r};
        DPCFG_TOTALS_OFS: rdata_r <= {out_total_r, in_total_r};
        DPCFG_MODULE_OFS: rdata_r <= {12'h0, dout_r, din_r};
        DPCFG_ERRRAW_OFS: rdata_r <= {err_b_r[3], err_b_r[2],
                                      err_b_r[1], err_b_r[0]};
        DPCFG_ERRCLS_OFS: rdata_r <= {23'h0, err_cnt_r == DPCFG_ERR_BYTES,
                                      err_cls};
        DPCFG_IRQST_OFS:  rdata_r <= {29'h0, irq_st_r};
        DPCFG_IRQMSK_OFS: rdata_r <= {29'h0, irq_msk_r};
        default:
        begin
          rdata_r <= DPCFG_ZERO32;
          rresp_r <= DPCFG_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && S_AXI_RREADY_I)
      rvalid_r <= 1'b0;
  end

endmodule

// file: inc/dpcfg_pkg.sv
// Package for the module layout and error reply decoder
package dpcfg_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] DPCFG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] DPCFG_CFGIN_OFS   = 8'h04;
  localparam logic [7:0] DPCFG_ERRIN_OFS   = 8'h08;
  localparam logic [7:0] DPCFG_TOTALS_OFS  = 8'h0C;
  localparam logic [7:0] DPCFG_MODULE_OFS  = 8'h10;
  localparam logic [7:0] DPCFG_ERRRAW_OFS  = 8'h14;
  localparam logic [7:0] DPCFG_ERRCLS_OFS  = 8'h18;
  localparam logic [7:0] DPCFG_IRQST_OFS   = 8'h1C;
  localparam logic [7:0] DPCFG_IRQMSK_OFS  = 8'h20;

  // Control register field positions
  localparam int DPCFG_CTRL_RESTART_BIT = 0;
  localparam int DPCFG_CTRL_ERRCLR_BIT  = 1;

  // Interrupt status bit positions
  localparam int DPCFG_IRQ_MODULE_BIT = 0;
  localparam int DPCFG_IRQ_ERRDONE_BIT = 1;
  localparam int DPCFG_IRQ_OVF_BIT     = 2;
  localparam int DPCFG_IRQ_W           = 3;

  // Reset values
  localparam logic [DPCFG_IRQ_W-1:0] DPCFG_IRQMSK_RST = 3'h0;
  localparam logic [31:0]            DPCFG_ZERO32     = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] DPCFG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DPCFG_RESP_SLVERR = 2'h2;

  // Identifier nibble codes
  localparam logic [3:0] DPCFG_ID_NODATA  = 4'h0;
  localparam logic [3:0] DPCFG_ID_SPEC_IN = 4'h4;
  localparam logic [3:0] DPCFG_ID_SPEC_OUT = 4'h8;
  localparam logic [3:0] DPCFG_ID_SPEC_IO = 4'hC;

  // Error reply byte codes
  localparam logic [7:0] DPCFG_SVC_TRANSPORT = 8'hD1;
  localparam logic [7:0] DPCFG_SVC_INITIATE  = 8'hD7;
  localparam logic [7:0] DPCFG_SVC_READ      = 8'hDE;
  localparam logic [7:0] DPCFG_SVC_WRITE     = 8'hDF;
  localparam logic [7:0] DPCFG_DEC_DPV1      = 8'h80;
  localparam logic [7:0] DPCFG_DEC_FMS       = 8'hFE;
  localparam logic [7:0] DPCFG_DEC_HART      = 8'hFF;
  localparam logic [3:0] DPCFG_CLS_APP       = 4'hA;
  localparam logic [3:0] DPCFG_CLS_ACCESS    = 4'hB;
  localparam logic [3:0] DPCFG_CLS_RESOURCE  = 4'hC;
  localparam logic [3:0] DPCFG_APP_FEAT      = 4'h9;
  localparam logic [3:0] DPCFG_APP_FAIL      = 4'h2;
  localparam logic [3:0] DPCFG_APP_VERS      = 4'h8;
  localparam logic [3:0] DPCFG_ACC_LAST      = 4'h9;
  localparam logic [3:0] DPCFG_RES_LAST      = 4'h3;
  localparam logic [2:0] DPCFG_ERR_BYTES     = 3'h4;

  // Service, decode and error classes
  localparam logic [2:0] DPCFG_SVC_K_TRANS = 3'h0;
  localparam logic [2:0] DPCFG_SVC_K_INIT  = 3'h1;
  localparam logic [2:0] DPCFG_SVC_K_READ  = 3'h2;
  localparam logic [2:0] DPCFG_SVC_K_WRITE = 3'h3;
  localparam logic [2:0] DPCFG_SVC_K_SLAVE = 3'h4;
  localparam logic [1:0] DPCFG_DEC_K_DPV1  = 2'h0;
  localparam logic [1:0] DPCFG_DEC_K_FMS   = 2'h1;
  localparam logic [1:0] DPCFG_DEC_K_HART  = 2'h2;
  localparam logic [1:0] DPCFG_DEC_K_UNDEF = 2'h3;
  localparam logic [1:0] DPCFG_CLS_K_APP   = 2'h1;
  localparam logic [1:0] DPCFG_CLS_K_ACC   = 2'h2;
  localparam logic [1:0] DPCFG_CLS_K_RES   = 2'h3;
  localparam logic [1:0] DPCFG_CLS_K_OTHER = 2'h0;

  // Decoded layout of one data direction
  typedef struct packed {
    logic       present;
    logic       word;
    logic       consistent;
    logic [6:0] units;
  } dpcfg_dir_t;

  // Classified error reply
  typedef struct packed {
    logic [2:0] service;
    logic [1:0] decode;
    logic [1:0] cls;
    logic       code_known;
  } dpcfg_err_t;

endpackage

// file: verification/dpcfg_decoder_asserts.sv
// Port checker for the layout and error reply decoder
`timescale 1ns/1ps
module dpcfg_decoder_asserts
  import dpcfg_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  // Write channels
  input wire logic [7:0]  S_AXI_AWADDR_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0]  S_AXI_WSTRB_I,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  // Read channels
  input wire logic [7:0]  S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0]  S_AXI_RRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  // Interrupt
  input wire logic        IRQ_O
);
  logic wr_go;
  logic rd_go;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Handshakes; the bench offers both write channels together
  assign wr_go = S_AXI_AWVALID_I && S_AXI_AWREADY_O
                 && S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wr_answer_a: assert property (wr_go |-> ##2 S_AXI_BVALID_O)
    else $error("write response late");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_go |=> S_AXI_RVALID_O)
    else $error("read data late");
  r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped");
  wr_block_a: assert property (S_AXI_BVALID_O
    |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while response pending");
  bad_addr_a: assert property (rd_go && S_AXI_ARADDR_I > DPCFG_IRQMSK_OFS
    |=> S_AXI_RRESP_O == DPCFG_RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  err_count_a:
    assert property (rd_go && S_AXI_ARADDR_I == DPCFG_ERRIN_OFS
    |=> S_AXI_RDATA_O <= 32'h4)
    else $error("error byte count above four");
  walk_state_a:
    assert property (rd_go && S_AXI_ARADDR_I == DPCFG_CTRL_OFS
    |=> $onehot(S_AXI_RDATA_O[3:0]) && S_AXI_RDATA_O[31:4] == 28'h0)
    else $error("walker state not one-hot");
  unit_range_a:
    assert property (rd_go && S_AXI_ARADDR_I == DPCFG_MODULE_OFS
    |=> (!S_AXI_RDATA_O[9] || S_AXI_RDATA_O[6:0] inside {[7'h1:7'h40]})
    && (!S_AXI_RDATA_O[19] || S_AXI_RDATA_O[16:10] inside {[7'h1:7'h40]}))
    else $error("unit count out of range");
  svc_range_a:
    assert property (rd_go && S_AXI_ARADDR_I == DPCFG_ERRCLS_OFS
    |=> S_AXI_RDATA_O[7:5] <= 3'h4)
    else $error("service class out of range");
  irq_mask_a: assert property (wr_go && S_AXI_AWADDR_I == DPCFG_IRQMSK_OFS
    && S_AXI_WSTRB_I[0] && S_AXI_WDATA_I[2:0] == 3'h0 |-> ##2 !IRQ_O)
    else $error("interrupt high with all masked");
  // Main scenarios
  cover property (wr_go ##2 S_AXI_BVALID_O);
  cover property ($rose(IRQ_O));
  cover property (rd_go && S_AXI_ARADDR_I == DPCFG_ERRCLS_OFS);
endmodule

bind dpcfg_decoder dpcfg_decoder_asserts u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .IRQ_O(IRQ_O));

// file: verification/dpcfg_slave_model.sv
// Behavioural fieldbus slave supplying layout and error reply bytes
`timescale 1ns/1ps
module dpcfg_slave_model
  import dpcfg_pkg::*;
(
  // Module layout string, byte 0 first
  output logic [0:13][7:0]     layout_o,
  // Failed access replies, byte 0 first
  output logic [0:5][0:3][7:0] reply_o
);
  // Special in, special in+out, special out, empty, plain word out
  assign layout_o = '{8'h42, 8'hFF, 8'hA5, 8'h5A, 8'hC1, 8'h00, 8'h7F,
                      8'h3C, 8'h80, 8'h85, 8'h02, 8'hAA, 8'h55, 8'h6F};
  // Every reply is exactly four bytes
  assign reply_o = '{'{8'hD1, 8'h80, 8'hA9, 8'h00},
                     '{8'hD7, 8'hFE, 8'hB7, 8'h11},
                     '{8'hDE, 8'hFF, 8'hC3, 8'h22},
                     '{8'hDF, 8'h80, 8'hC4, 8'h33},
                     '{8'h12, 8'h33, 8'hA5, 8'h44},
                     '{8'hDE, 8'h80, 8'h50, 8'h55}};
endmodule

// file: verification/dpcfg_decoder_bench.sv
// Self-checking bench for the layout and error reply decoder
`timescale 1ns/1ps
module dpcfg_decoder_bench
  import dpcfg_pkg::*;
();
  logic        clk, rst, aw_v, w_v, b_rdy, ar_v, r_rdy;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rd_d;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp, rsp;
  logic [9:0]  f;
  logic [15:0] n;
  logic [7:0]  b;
  int          error_cnt;
  int          total_checks;
  logic [0:13][7:0]     lay;
  logic [0:5][0:3][7:0] rep;
  logic [3:0]  codes [0:12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
                                4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
  logic [3:0]  st_exp [0:13] = '{4'h4, 4'h8, 4'h8, 4'h1, 4'h2, 4'h4, 4'h8,
                                 4'h1, 4'h2, 4'h1, 4'h8, 4'h8, 4'h1, 4'h1};

  dpcfg_decoder dut (
    .CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(aw_addr),
    .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(w_data),
    .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
    .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_rdy),
    .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_v),
    .S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp),
    .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_rdy), .IRQ_O(irq));

  dpcfg_slave_model slave (
    .layout_o(lay),
    .reply_o(rep));

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // A stuck handshake ends the run rather than hanging it
  task automatic tmo(input int k);
    if (k >= 50)
    begin
      error_cnt++;
      $display("BAD %0t bus wait too long", $time);
      finish_test();
    end
  endtask

  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    aw_addr <= a;
    aw_v    <= 1'b1;
    w_data  <= d;
    w_v     <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
      if (aw_v && aw_rdy)
        aw_v <= 1'b0;
      if (w_v && w_rdy)
        w_v <= 1'b0;
      // Ready follows the answer, so the slave must hold it a cycle
      if (b_v && !b_rdy)
        b_rdy <= 1'b1;
    end
    while (!(b_v && b_rdy) && k < 50);
    rsp = b_resp;
    b_rdy <= 1'b0;
    tmo(k);
    // Idle edge so ready is never lowered and raised in one step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    ar_addr <= a;
    ar_v    <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
      if (ar_v && ar_rdy)
        ar_v <= 1'b0;
      if (r_v && !r_rdy)
        r_rdy <= 1'b1;
    end
    while (!(r_v && r_rdy) && k < 50);
    rd_d = r_data;
    rsp = r_resp;
    r_rdy <= 1'b0;
    tmo(k);
    @(posedge clk);
  endtask

  // Reference classification of a failed access reply
  function automatic logic [31:0] cls_exp(input logic [7:0] b0, b1, b2);
    logic [2:0] s;
    logic [1:0] d;
    logic [1:0] c;
    logic       k;
    case (b0)
      DPCFG_SVC_TRANSPORT: s = 3'h0;
      DPCFG_SVC_INITIATE:  s = 3'h1;
      DPCFG_SVC_READ:      s = 3'h2;
      DPCFG_SVC_WRITE:     s = 3'h3;
      default:             s = 3'h4;
    endcase
    d = (b1 == 8'h80) ? 2'h0 : (b1 == 8'hFE) ? 2'h1 : (b1 == 8'hFF) ? 2'h2
        : 2'h3;
    c = (b2[7:4] == 4'hA) ? 2'h1 : (b2[7:4] == 4'hB) ? 2'h2
        : (b2[7:4] == 4'hC) ? 2'h3 : 2'h0;
    case (b2[7:4])
      4'hA:    k = b2[3:0] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
      4'hB:    k = b2[3:0] <= 4'h9;
      4'hC:    k = b2[3:0] <= 4'h3;
      default: k = 1'b0;
    endcase
    return {23'h0, 1'b1, s, d, c, k};
  endfunction

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    {aw_addr, aw_v, w_data, w_v, b_rdy, ar_addr, ar_v, r_rdy} = '0;
    w_strb = 4'hF;
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset state, ignored lane, unmapped place
    w_strb <= 4'hE;
    wr(DPCFG_IRQMSK_OFS, 32'h7);
    w_strb <= 4'hF;
    rd(DPCFG_IRQMSK_OFS);
    chk(rd_d, 32'h0, "mask");
    chk({31'h0, irq}, 32'h0, "irq idle");
    wr(8'h24, 32'h1);
    chk({30'h0, rsp}, {30'h0, DPCFG_RESP_SLVERR}, "bad write");
    rd(8'h24);
    chk({30'h0, rsp}, {30'h0, DPCFG_RESP_SLVERR}, "bad read");
    $display("test registers done");
    // Every plain identifier, lengths 1 and 16 alternating
    for (int i = 0; i < 13; i++)
    begin
      b = {codes[i], (i % 2) ? 4'hF : 4'h0};
      f = {1'b1, codes[i][2], codes[i][3], {3'h0, b[3:0]} + 7'h1};
      n = ({12'h0, b[3:0]} + 16'h1) << codes[i][2];
      wr(DPCFG_CTRL_OFS, 32'h1);
      wr(DPCFG_CFGIN_OFS, {24'h0, b});
      rd(DPCFG_MODULE_OFS);
      chk(rd_d, {12'h0, codes[i][1] ? f : 10'h0, codes[i][0] ? f : 10'h0},
          "layout");
      rd(DPCFG_TOTALS_OFS);
      chk(rd_d, {codes[i][1] ? n : 16'h0, codes[i][0] ? n : 16'h0},
          "totals");
    end
    $display("test plain identifiers done");
    // Whole string with descriptors and vendor bytes
    wr(DPCFG_CTRL_OFS, 32'h1);
    for (int i = 0; i < 14; i++)
    begin
      wr(DPCFG_CFGIN_OFS, {24'h0, lay[i]});
      rd(DPCFG_CTRL_OFS);
      chk(rd_d, {28'h0, st_exp[i]}, "walk");
      if (i == 1)
      begin
        rd(DPCFG_MODULE_OFS);
        chk(rd_d, {22'h0, 3'b111, 7'h40}, "desc");
      end
    end
    rd(DPCFG_TOTALS_OFS);
    chk(rd_d, {16'd39, 16'd256}, "sum");
    rd(DPCFG_MODULE_OFS);
    chk(rd_d, {12'h0, 3'b110, 7'h10, 10'h0}, "last");
    rd(DPCFG_IRQST_OFS);
    chk(rd_d, 32'h1, "done flag");
    wr(DPCFG_IRQMSK_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(DPCFG_IRQST_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test walk done");
    // Failed access replies
    wr(DPCFG_IRQMSK_OFS, 32'h2);
    for (int r = 0; r < 6; r++)
    begin
      wr(DPCFG_CTRL_OFS, 32'h2);
      for (int j = 0; j < 4; j++)
        wr(DPCFG_ERRIN_OFS, {24'h0, rep[r][j]});
      rd(DPCFG_ERRCLS_OFS);
      chk(rd_d, cls_exp(rep[r][0], rep[r][1], rep[r][2]),
          "class");
      rd(DPCFG_ERRRAW_OFS);
      chk(rd_d, {rep[r][3], rep[r][2], rep[r][1], rep[r][0]},
          "raw");
      rd(DPCFG_ERRIN_OFS);
      chk(rd_d, 32'h4, "count");
    end
    chk({31'h0, irq}, 32'h1, "irq reply");
    wr(DPCFG_IRQMSK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(DPCFG_ERRIN_OFS, 32'h99);
    rd(DPCFG_IRQST_OFS);
    chk(rd_d, 32'h6, "overflow");
    wr(DPCFG_IRQMSK_OFS, 32'h4);
    chk({31'h0, irq}, 32'h1, "irq overflow");
    wr(DPCFG_IRQST_OFS, 32'h7);
    chk({31'h0, irq}, 32'h0, "irq off");
    $display("test error replies done");
    finish_test();
  end
endmodule
